//--- adcs_ctrl.sv
// What this block does
// - start line low at end: power down
// - rising start edge powers up, 1.5 us
// - falling edge starts 2.3 us conversion, stores result
// - early fall waits for power-up, then converts
// - rising start edge enables serial port
// - early read shifts out previous result
// - readout works while powered down
// - rising start edge clears bit counter
// - clocks after ten bits are ignored
// - tenth clock falling edge resets counter
// - first rising clock drives first bit
// - data output released on tenth falling edge
// - free-running or burst serial clock both work
// - no bits before a rising start edge
// - new result waits until read completes
// - result is ten-bit straight binary
//
// top of the converter sequencing and serial readout logic
// assumes conv_start_n and sclk are asynchronous pins and adc_code comes from the
// converter core on clk
`timescale 1ns/1ps
module adcs_ctrl
	import adcs_pkg::*;
#(
	parameter int RESULT_W   = RESULT_BITS,
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// host pins
	input  wire logic                conv_start_n,
	input  wire logic                sclk,
	output logic                     dout_o,
	output logic                     dout_oe,
	// converter core
	input  wire logic [RESULT_W-1:0] adc_code,
	output logic                     core_power_on,
	output logic                     core_converting,
	output logic                     core_hold
);

	// pin synchronisers
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] pin_async;

	assign pin_async = {sclk, conv_start_n};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_meta_reg[g] <= PIN_RESET[g];
					pin_sync_reg[g] <= PIN_RESET[g];
					pin_prev_reg[g] <= PIN_RESET[g];
				end else begin
					pin_meta_reg[g] <= pin_async[g];
					pin_sync_reg[g] <= pin_meta_reg[g];
					pin_prev_reg[g] <= pin_sync_reg[g];
				end
			end
		end
	endgenerate

	logic start_level;
	logic start_rise;
	logic start_fall;
	logic sclk_rise;
	logic sclk_fall;

	assign start_level = pin_sync_reg[0];
	assign start_rise  = pin_sync_reg[0] && !pin_prev_reg[0];
	assign start_fall  = !pin_sync_reg[0] && pin_prev_reg[0];
	assign sclk_rise   = pin_sync_reg[1] && !pin_prev_reg[1];
	assign sclk_fall   = !pin_sync_reg[1] && pin_prev_reg[1];

	// sequencer state
	adcs_state_e         state_reg;
	adcs_state_e         state_next;
	logic [TIMER_W-1:0]  timer_reg;
	logic                early_fall_reg;
	logic [RESULT_W-1:0] result_reg;
	logic                timer_done;

	assign timer_done = (timer_reg == '0);

	// result stream into the fifo and out of it
	adcs_stream_if #(.WIDTH(RESULT_W)) res_in ();
	adcs_stream_if #(.WIDTH(RESULT_W)) res_out ();

	assign res_in.valid = (state_reg == ST_STORE);
	assign res_in.data  = result_reg;

	adcs_fifo #(
		.WIDTH (RESULT_W),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.clk    (clk),
		.arst_n (arst_n),
		.wr     (res_in.snk),
		.rd     (res_out.src)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_POWER_DOWN: begin
				if (start_rise) begin
					state_next = ST_POWER_UP;
				end
			end
			ST_POWER_UP: begin
				if (timer_done) begin
					if (early_fall_reg || start_fall) begin
						state_next = ST_CONVERT;
					end else begin
						state_next = ST_READY;
					end
				end
			end
			ST_READY: begin
				if (start_fall) begin
					state_next = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (timer_done) begin
					state_next = ST_STORE;
				end
			end
			ST_STORE: begin
				if (res_in.ready) begin
					if (!start_level) begin
						state_next = ST_POWER_DOWN;
					end else begin
						state_next = ST_READY;
					end
				end
			end
			default: begin
				state_next = ST_POWER_DOWN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_POWER_DOWN;
		end else begin
			state_reg <= state_next;
		end
	end

	// power-up and conversion timer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_reg <= '0;
		end else if (state_reg == ST_POWER_DOWN && state_next == ST_POWER_UP) begin
			timer_reg <= TIMER_W'(PWRUP_CYCLES - 1);
		end else if (state_reg != ST_CONVERT && state_next == ST_CONVERT) begin
			timer_reg <= TIMER_W'(CONV_CYCLES - 1);
		end else if (!timer_done) begin
			timer_reg <= timer_reg - 1'b1;
		end
	end

	// a fall during power-up is remembered until power-up is over
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			early_fall_reg <= 1'b0;
		end else if (state_reg != ST_POWER_UP) begin
			early_fall_reg <= 1'b0;
		end else if (start_fall) begin
			early_fall_reg <= 1'b1;
		end
	end

	// capture the core's code at the end of a conversion
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result_reg <= RESULT_RESET;
		end else if (state_reg == ST_CONVERT && timer_done) begin
			result_reg <= adc_code;
		end
	end

	assign core_power_on   = (state_reg != ST_POWER_DOWN);
	assign core_converting = (state_reg == ST_CONVERT);
	assign core_hold       = (state_reg == ST_CONVERT);

	// serial readout, independent of power state
	logic [RESULT_W-1:0] shift_reg;
	logic [BITCNT_W-1:0] bit_cnt_reg;
	logic                armed_reg;
	logic                dout_reg;
	logic                dout_oe_reg;
	logic                last_fall;

	assign last_fall = armed_reg && sclk_fall && dout_oe_reg
		&& (bit_cnt_reg == BITCNT_W'(RESULT_W - 1));

	// load only between reads, so a read in flight keeps its word
	assign res_out.ready = !dout_oe_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= RESULT_RESET;
		end else if (res_out.valid && res_out.ready) begin
			shift_reg <= res_out.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			armed_reg <= 1'b0;
		end else if (start_rise) begin
			armed_reg <= 1'b1;
		end else if (last_fall) begin
			armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_reg <= '0;
		end else if (start_rise) begin
			bit_cnt_reg <= '0;
		end else if (last_fall) begin
			bit_cnt_reg <= '0;
		end else if (armed_reg && dout_oe_reg && sclk_fall) begin
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout_reg    <= 1'b0;
			dout_oe_reg <= 1'b0;
		end else if (start_rise) begin
			dout_oe_reg <= 1'b0;
		end else if (last_fall) begin
			dout_oe_reg <= 1'b0;
		end else if (armed_reg && sclk_rise) begin
			dout_reg    <= shift_reg[RESULT_W - 1 - int'(bit_cnt_reg)];
			dout_oe_reg <= 1'b1;
		end
	end

	assign dout_o  = dout_reg;
	assign dout_oe = dout_oe_reg;

endmodule : adcs_ctrl

//--- adcs_pkg.sv
// constants and types of the converter sequencing and serial readout block
// assumes a single 100 MHz system clock
package adcs_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWRUP_TIME_NS = 1500;
	localparam int CONV_TIME_NS  = 2300;
	localparam int PWRUP_CYCLES  = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W       = 12;

	// result and serial framing
	localparam int RESULT_BITS = 10;
	localparam int BITCNT_W    = 4;
	localparam int FIFO_DEPTH  = 8;

	// reset values
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;
	localparam logic [1:0]             PIN_RESET    = 2'h0;

	// converter sequence
	typedef enum logic [2:0] {
		ST_POWER_DOWN = 3'b000,
		ST_POWER_UP   = 3'b001,
		ST_READY      = 3'b010,
		ST_CONVERT    = 3'b011,
		ST_STORE      = 3'b100
	} adcs_state_e;

endpackage : adcs_pkg

//--- adcs_stream_if.sv
// valid/ready word stream between the sequencer and the result fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface adcs_stream_if #(
	parameter int WIDTH = 10
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : adcs_stream_if

//--- adcs_fifo.sv
// small result fifo, width and depth set by parameters
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module adcs_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// filling side
	adcs_stream_if.snk wr,
	// draining side
	adcs_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign wr.ready = (count_reg != (AW+1)'(DEPTH));
	assign rd.valid = (count_reg != '0);
	assign rd.data  = mem_reg[rd_ptr_reg];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= wr.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : adcs_fifo

//--- adcs_ctrl_assertions.sv
// pin checker of the converter sequencer and serial port
// assumes it is bound into adcs_ctrl
`timescale 1ns/1ps
module adcs_chk #(parameter int RESULT_W = 10, parameter int FIFO_WORDS = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// host pins
	input wire logic conv_start_n,
	input wire logic sclk,
	input wire logic dout_o,
	input wire logic dout_oe,
	// core side
	input wire logic [RESULT_W-1:0] adc_code,
	input wire logic core_power_on,
	input wire logic core_converting,
	input wire logic core_hold
);
	logic [8:0] conv_cnt_reg;
	logic [8:0] pwr_cnt_reg;
	logic [3:0] fall_cnt_reg;
	logic sclk_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_cnt_reg <= '0;
			pwr_cnt_reg <= '0;
			fall_cnt_reg <= '0;
			sclk_reg <= 1'b0;
		end else begin
			conv_cnt_reg <= core_converting ? conv_cnt_reg + 9'h001 : '0;
			pwr_cnt_reg <= !core_power_on ? '0 : pwr_cnt_reg + {8'h00, pwr_cnt_reg != 9'h1ff};
			fall_cnt_reg <= !dout_oe ? '0 : fall_cnt_reg + {3'h0, sclk_reg & ~sclk};
			sclk_reg <= sclk;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	hold_same_a: assert property (core_hold == core_converting)
		else $error("hold differs");
	conv_len_a: assert property ($fell(core_converting) |-> conv_cnt_reg == 9'h0e6)
		else $error("conversion length");
	conv_pwr_a: assert property (core_converting |-> core_power_on)
		else $error("unpowered conversion");
	conv_begin_a: assert property ($fell(conv_start_n) && !core_converting && pwr_cnt_reg >= 9'h096 |-> ##[3:5] core_converting)
		else $error("conversion not started");
	pwr_wait_a: assert property ($rose(core_converting) |-> pwr_cnt_reg >= 9'h096)
		else $error("power-up cut short");
	auto_down_a: assert property ($fell(core_converting) && !conv_start_n && !$past(conv_start_n, 4) |-> ##[1:8] !core_power_on)
		else $error("no power-down");
	stay_up_a: assert property ($fell(core_converting) && conv_start_n && $past(conv_start_n, 4) |=> core_power_on[*4])
		else $error("powered down early");
	wake_a: assert property ($rose(conv_start_n) && !core_power_on |-> ##[2:6] core_power_on)
		else $error("no power-up");
	fall_bound_a: assert property (fall_cnt_reg <= 4'ha)
		else $error("clocks after tenth bit used");
	oe_release_a: assert property (fall_cnt_reg == 4'ha |-> ##[0:8] !dout_oe)
		else $error("output not released");
	cover property ($fell(core_converting));
	cover property (fall_cnt_reg == 4'ha);
	cover property ($rose(core_converting) && pwr_cnt_reg < 9'h0a0);
endmodule : adcs_chk
bind adcs_ctrl adcs_chk #(.RESULT_W(RESULT_W), .FIFO_WORDS(FIFO_WORDS)) u_chk (.clk(clk), .arst_n(arst_n),
	.conv_start_n(conv_start_n), .sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe), .adc_code(adc_code),
	.core_power_on(core_power_on), .core_converting(core_converting), .core_hold(core_hold));

//--- adcs_host_model.sv
// host model: start line and gated serial clock
// assumes the bench clock paces its edges
`timescale 1ns/1ps
module adcs_host_model (
	// pacing
	input wire logic clk,
	// pins
	output logic conv_start_n,
	output logic sclk,
	input wire logic dout
);
	initial begin
		conv_start_n = 1'b0;
		sclk = 1'b0;
	end
	task automatic wait_clk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : wait_clk
	task automatic set_start(input logic v);
		conv_start_n = v;
	endtask : set_start
	task automatic shift(input int k, output logic [9:0] q);
		q = '0;
		for (int i = 0; i < k; i++) begin
			sclk = 1'b1;
			wait_clk(5);
			sclk = 1'b0;
			q = {q[8:0], dout};
			wait_clk(3);
		end
	endtask : shift
endmodule : adcs_host_model

//--- tb.sv
// bench of the converter sequencer and serial readout
// assumes the host model drives the pins, the bench acts as core
`timescale 1ns/1ps
module tb;
	import adcs_pkg::*;
	logic clk;
	logic arst_n;
	logic conv_start_n;
	logic sclk;
	logic dout_o;
	logic dout_oe;
	logic dout_last = 1'b0;
	logic core_power_on;
	logic core_converting;
	logic core_hold;
	logic [9:0] adc_code;
	logic [9:0] w;
	int n;
	int bad_count = 0;
	int n_checks = 0;
	wire dout_w = dout_oe ? dout_o : ~dout_last;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (dout_oe) dout_last <= dout_o;
	adcs_ctrl dut (.clk(clk), .arst_n(arst_n), .conv_start_n(conv_start_n), .sclk(sclk), .dout_o(dout_o),
		.dout_oe(dout_oe), .adc_code(adc_code), .core_power_on(core_power_on),
		.core_converting(core_converting), .core_hold(core_hold));
	adcs_host_model host (.clk(clk), .conv_start_n(conv_start_n), .sclk(sclk), .dout(dout_w));
	task automatic check_word(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word
	task automatic check_bit(input string what, input logic exp, input logic got);
		check_word(what, {9'h000, exp}, {9'h000, got});
	endtask : check_bit
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic wait_conv(input logic v);
		n = 0;
		while (core_converting !== v) begin
			host.wait_clk(1);
			n++;
			if (n > 1000) begin
				bad_count++;
				$display("MISMATCH converting expected %b seen timeout", v);
				print_verdict();
			end
		end
	endtask : wait_conv
	task automatic read_word();
		logic [9:0] a;
		logic [9:0] b;
		host.shift(8, a);
		host.shift(8, b);
		w = {a[7:0], b[7:6]};
		check_bit("released", 1'b0, dout_oe);
	endtask : read_word
	task automatic t_mode2();
		adc_code = 10'h2a5;
		host.set_start(1'b1);
		host.wait_clk(200);
		host.set_start(1'b0);
		wait_conv(1'b1);
		wait_conv(1'b0);
		host.wait_clk(10);
		check_bit("power", 1'b0, core_power_on);
		read_word();
		check_word("mode2 word", 10'h2a5, w);
		host.shift(3, w);
		check_bit("ignored clocks", 1'b0, dout_oe);
		$display("mode2 done");
	endtask : t_mode2
	task automatic t_early();
		adc_code = 10'h1c3;
		host.set_start(1'b1);
		host.wait_clk(20);
		host.set_start(1'b0);
		wait_conv(1'b1);
		check_bit("late start", 1'b1, n + 20 >= PWRUP_CYCLES);
		wait_conv(1'b0);
		host.wait_clk(10);
		check_bit("power", 1'b0, core_power_on);
		$display("early fall done");
	endtask : t_early
	task automatic t_reads();
		adc_code = 10'h3f0;
		host.set_start(1'b1);
		host.wait_clk(160);
		host.set_start(1'b0);
		wait_conv(1'b1);
		host.wait_clk(50);
		host.set_start(1'b1);
		host.wait_clk(150);
		host.shift(10, w);
		check_word("previous word", 10'h1c3, w);
		check_bit("power held", 1'b1, core_power_on);
		adc_code = 10'h0f0;
		host.set_start(1'b0);
		wait_conv(1'b1);
		host.wait_clk(10);
		host.set_start(1'b1);
		host.wait_clk(4);
		host.shift(10, w);
		check_word("deferred word", 10'h3f0, w);
		wait_conv(1'b0);
		adc_code = 10'h155;
		host.set_start(1'b0);
		host.wait_clk(4);
		host.set_start(1'b1);
		host.wait_clk(4);
		host.shift(10, w);
		check_word("mode1 word", 10'h0f0, w);
		check_bit("hold", 1'b1, core_hold);
		wait_conv(1'b0);
		host.wait_clk(10);
		check_bit("power kept", 1'b1, core_power_on);
		$display("reads done");
	endtask : t_reads
	initial begin
		arst_n = 1'b0;
		adc_code = 10'h000;
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		host.wait_clk(5);
		t_mode2();
		t_early();
		t_reads();
		print_verdict();
	end
endmodule : tb
